// [rtl/bcg_pkg.sv]
// Package for the baud clock generator: register map, fields, resets.
// Assumes a single reference clock domain and the serial config link.
package bcg_pkg;

    // ----------------------------------------------------------------
    // Register bank
    // ----------------------------------------------------------------
    localparam int         NUM_REGS       = 20;
    localparam logic [4:0] OFS_TRANSMITTER_CONTROL      = 5'h0E;
    localparam logic [4:0] OFS_BAUD_DIV   = 5'h0F;
    localparam logic [4:0] OFS_SCALER_SELECT      = 5'h10;
    localparam logic [7:0] TRANSMITTER_CONTROL_RST      = 8'h00;
    localparam logic [7:0] SCALER_SELECT_RST      = 8'hB0;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int         TXC_PD_BIT     = 7;
    localparam int         TXC_CLOCK_OUTPUT_POWER_DOWN_BIT   = 6;
    localparam int         SC_CSS_MSB     = 7;
    localparam int         SC_PSC_MSB     = 4;
    localparam int         SC_PSC_LSB     = 2;
    localparam int         SC_ASC_MSB     = 1;
    localparam logic [2:0] PSC_CODE_DIV16 = 3'h4;

    // ----------------------------------------------------------------
    // Serial header byte: read flag and address bits
    // ----------------------------------------------------------------
    localparam int         HDR_RD_BIT     = 7;
    localparam int         HDR_ADDR_MSB   = 4;
    localparam logic [2:0] LAST_BIT       = 3'h7;

    // ----------------------------------------------------------------
    // Timing and buffering
    // ----------------------------------------------------------------
    localparam int         PD_TIMEOUT_CYC = 65536;
    localparam int         WR_FIFO_DEPTH  = 32;
    localparam int         WR_FIFO_WIDTH  = 13;

endpackage : bcg_pkg

// [rtl/bcg_fifo.sv]
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; push and pop may share a cycle.
`timescale 1ns/100ps
module bcg_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // Fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    rp_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;

    // Honest flags straight from the occupancy count
    assign in_ready_out  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid_out = (cnt_r != '0);
    assign out_data_out  = mem_r[rp_r];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    // Storage needs no reset; only pointers and count carry state
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_r[wp_r] <= in_data_in;
        end
    end

    // Pointers and count
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= AW'((wp_r == AW'(DEPTH-1)) ? 0 : wp_r + 1'b1);
            end
            if (pop) begin
                rp_r <= AW'((rp_r == AW'(DEPTH-1)) ? 0 : rp_r + 1'b1);
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

endmodule : bcg_fifo

// [rtl/bcg_top.sv]
// Baud clock generator with its serial configuration register bank.
// Assumes SCK, EN and SDIO are asynchronous pins; PA_ON_IN and
// SYNC_EN_IN come from the transmit state machine on SYS_CLK_IN.
`timescale 1ns/100ps
module bcg_top #(
    parameter int PD_TIMEOUT = bcg_pkg::PD_TIMEOUT_CYC,
    parameter int FIFO_DEPTH = bcg_pkg::WR_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic SYS_CLK_IN,
    input  wire logic RST_IN,
    // Serial configuration link
    input  wire logic SCK_IN,
    input  wire logic EN_IN,
    input  wire logic SDIO_IN,
    output logic      SDIO_OUT,
    output logic      SDIO_OE_OUT,
    // Transmit state machine
    input  wire logic PA_ON_IN,
    input  wire logic SYNC_EN_IN,
    // Clock output pin and data
    output logic      CLOCK_OUTPUT_PIN_OUT,
    output logic      CLOCK_OUTPUT_PIN_OE_OUT,
    output logic      TRANSMIT_DATA_OUT,
    output logic      OSC_RUN_OUT
);
    import bcg_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0]  sck_s;
        logic [2:0]  en_s;
        logic [1:0]  sdio_s;
        logic        pol;
        logic [2:0]  bit_cnt;
        logic        hdr_done;
        logic        rd;
        logic [4:0]  addr;
        logic [7:0]  sh_in;
        logic [7:0]  sh_out;
        logic        sdo;
        logic        sdo_oe;
        logic [7:0]  transmitter_control;
        logic [31:0] idle_cnt;
        logic [6:0]  psc_cnt;
        logic        psc_tgl;
        logic [7:0]  bd_cnt;
        logic        bd_clk;
        logic [2:0]  asc_cnt;
        logic        tx_data;
        logic        ck_out;
        logic        ck_oe;
    } bcg_state_t;

    bcg_state_t  st_r;
    bcg_state_t  st_nxt;
    logic [7:0]  bank_r [NUM_REGS];

    // Combinational helpers
    logic        sck_rise;
    logic        sck_fall;
    logic        act_edge;
    logic        opp_edge;
    logic        en_rise;
    logic        en_fall;
    logic        en_lvl;
    logic        sdio_lvl;
    logic        timeout;
    logic        force16;
    logic        hw_wr;
    logic [7:0]  scaler_select;
    logic [2:0]  psc_k;
    logic [6:0]  psc_mask;
    logic        psc_tick;
    logic        psc_lvl;
    logic        bd_wrap;
    logic        bd_rise;
    logic [2:0]  asc_mask;
    logic        asc_tick;
    logic        byte_done;
    logic [7:0]  shifted;
    logic [4:0]  next_addr;
    logic [7:0]  rd_byte;
    logic [4:0]  rd_addr;
    logic        ck_val;
    logic        ck_en;

    // Write FIFO wiring
    logic                     wf_in_valid;
    logic                     wf_in_ready;
    logic [WR_FIFO_WIDTH-1:0] wf_in_data;
    logic                     wf_out_valid;
    logic                     wf_out_ready;
    logic [WR_FIFO_WIDTH-1:0] wf_out_data;

    // ----------------------------------------------------------------
    // Pin edges and hardware events
    // ----------------------------------------------------------------
    // Edge detectors read only the second sync stage and its copy
    assign sck_rise  = st_r.sck_s[1] && !st_r.sck_s[2];
    assign sck_fall  = !st_r.sck_s[1] && st_r.sck_s[2];
    assign en_lvl    = st_r.en_s[1];
    assign en_rise   = st_r.en_s[1] && !st_r.en_s[2];
    assign en_fall   = !st_r.en_s[1] && st_r.en_s[2];
    assign sdio_lvl  = st_r.sdio_s[1];
    assign act_edge  = en_lvl && (st_r.pol ? sck_rise : sck_fall);
    assign opp_edge  = en_lvl && (st_r.pol ? sck_fall : sck_rise);
    assign timeout   = !en_lvl && (st_r.idle_cnt == 32'(PD_TIMEOUT - 1));
    assign force16   = en_rise && !sdio_lvl;
    // Hardware bank writes take priority; the drain stalls for them
    assign hw_wr     = force16 || timeout;

    // ----------------------------------------------------------------
    // Divider chain decode
    // ----------------------------------------------------------------
    assign scaler_select     = bank_r[OFS_SCALER_SELECT];
    assign psc_k     = scaler_select[SC_PSC_MSB:SC_PSC_LSB];
    assign psc_mask  = 7'((8'h01 << psc_k) - 8'h01);
    assign psc_tick  = !st_r.transmitter_control[TXC_PD_BIT] && ((st_r.psc_cnt & psc_mask) == psc_mask);
    // Ratio 1 cannot be shown as a level at full rate; use a toggle
    assign psc_lvl   = (psc_k == 3'h0) ? st_r.psc_tgl : st_r.psc_cnt[3'(psc_k - 3'h1)];
    assign bd_wrap   = psc_tick && (st_r.bd_cnt == bank_r[OFS_BAUD_DIV]);
    assign bd_rise   = bd_wrap && !st_r.bd_clk;
    assign asc_mask  = 3'((4'h1 << scaler_select[SC_ASC_MSB:0]) - 4'h1);
    assign asc_tick  = PA_ON_IN && bd_rise && ((st_r.asc_cnt & asc_mask) == asc_mask);

    // ----------------------------------------------------------------
    // Serial byte assembly and read data
    // ----------------------------------------------------------------
    assign shifted   = {st_r.sh_in[6:0], sdio_lvl};
    assign byte_done = act_edge && (st_r.bit_cnt == LAST_BIT);
    assign next_addr = st_r.hdr_done ? st_r.addr + 5'h01 : shifted[HDR_ADDR_MSB:0];
    assign rd_addr   = next_addr;

    // Read mux; addresses past the bank read as zero
    always_comb begin
        if (rd_addr == OFS_TRANSMITTER_CONTROL) begin
            rd_byte = st_r.transmitter_control;
        end else if (rd_addr < 5'(NUM_REGS)) begin
            rd_byte = bank_r[rd_addr];
        end else begin
            rd_byte = 8'h00;
        end
    end

    // Completed write bytes enter the FIFO with their address
    assign wf_in_valid  = byte_done && st_r.hdr_done && !st_r.rd;
    assign wf_in_data   = {st_r.addr, shifted};
    assign wf_out_ready = !hw_wr;

    // Clock output source selection
    always_comb begin
        ck_val = 1'b0;
        ck_en  = 1'b0;
        if (st_r.transmitter_control[TXC_CLOCK_OUTPUT_POWER_DOWN_BIT]) begin
            ck_en = 1'b0;
        end else if (!scaler_select[SC_CSS_MSB]) begin
            ck_en = PA_ON_IN;
            case (scaler_select[SC_CSS_MSB-1 -: 2])
                2'h0:    ck_val = 1'b0;
                2'h1:    ck_val = psc_lvl;
                2'h2:    ck_val = st_r.bd_clk;
                default: ck_val = !st_r.bd_clk;
            endcase
        end else begin
            ck_en = 1'b1;
            case (scaler_select[SC_CSS_MSB-1 -: 2])
                2'h0:    ck_val = 1'b0;
                2'h1:    ck_val = psc_lvl;
                2'h2:    ck_val = PA_ON_IN && st_r.bd_clk;
                default: ck_val = PA_ON_IN ? !st_r.bd_clk : 1'b1;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;

        // Two-stage synchronisers plus one delayed copy for edges
        st_nxt.sck_s  = {st_r.sck_s[1:0], SCK_IN};
        st_nxt.en_s   = {st_r.en_s[1:0], EN_IN};
        st_nxt.sdio_s = {st_r.sdio_s[0], SDIO_IN};

        // Serial framing
        if (en_rise) begin
            st_nxt.pol = st_r.sck_s[1];
        end
        if (!en_lvl) begin
            // Frame ends; auto-increment stops here
            st_nxt.bit_cnt  = 3'h0;
            st_nxt.hdr_done = 1'b0;
            st_nxt.rd       = 1'b0;
            st_nxt.sdo_oe   = 1'b0;
        end else if (act_edge) begin
            st_nxt.sh_in   = shifted;
            st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
            if (byte_done) begin
                // Either a header or a data byte; both keep framing
                st_nxt.hdr_done = 1'b1;
                st_nxt.addr     = next_addr;
                if (!st_r.hdr_done) begin
                    st_nxt.rd = shifted[HDR_RD_BIT];
                end
                // Preload the byte the host reads next
                st_nxt.sh_out = rd_byte;
                st_nxt.sdo    = rd_byte[7];
                st_nxt.sdo_oe = st_r.hdr_done ? st_r.rd : shifted[HDR_RD_BIT];
            end
        end else if (opp_edge && st_r.bit_cnt != 3'h0) begin
            st_nxt.sh_out = {st_r.sh_out[6:0], 1'b0};
            st_nxt.sdo    = st_r.sh_out[6];
        end

        // Enable-low timer for the reset command
        if (en_lvl) begin
            st_nxt.idle_cnt = 32'h0;
        end else if (st_r.idle_cnt != 32'(PD_TIMEOUT)) begin
            st_nxt.idle_cnt = st_r.idle_cnt + 32'h1;
        end

        // Transmit control: hardware event wins over queued writes
        if (timeout) begin
            st_nxt.transmitter_control = sdio_lvl ? st_r.transmitter_control : TRANSMITTER_CONTROL_RST;
            st_nxt.transmitter_control[TXC_PD_BIT] = 1'b1;
        end else if (wf_out_valid && wf_out_ready &&
                     wf_out_data[12:8] == OFS_TRANSMITTER_CONTROL) begin
            st_nxt.transmitter_control = wf_out_data[7:0];
        end

        // Prescaler free-runs while the oscillator runs
        if (!st_r.transmitter_control[TXC_PD_BIT]) begin
            st_nxt.psc_cnt = st_r.psc_cnt + 7'h01;
            st_nxt.psc_tgl = !st_r.psc_tgl;
        end

        // Baud counter and afterscaler
        if (!PA_ON_IN) begin
            st_nxt.bd_cnt  = 8'h00;
            st_nxt.bd_clk  = 1'b0;
            st_nxt.asc_cnt = 3'h0;
        end else begin
            if (bd_wrap) begin
                st_nxt.bd_cnt = 8'h00;
                st_nxt.bd_clk = !st_r.bd_clk;
            end else if (psc_tick) begin
                st_nxt.bd_cnt = st_r.bd_cnt + 8'h01;
            end
            if (bd_rise) begin
                st_nxt.asc_cnt = st_r.asc_cnt + 3'h1;
            end
        end

        // Transmit data always leaves through a reference-clock flop
        if (!SYNC_EN_IN) begin
            st_nxt.tx_data = sdio_lvl;
        end else if (asc_tick) begin
            st_nxt.tx_data = sdio_lvl;
        end

        // Registered clock output pin
        st_nxt.ck_out = ck_val;
        st_nxt.ck_oe  = ck_en;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Dynamic reset restores only transmit control among the registers
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            st_r       <= '0;
            st_r.transmitter_control <= TRANSMITTER_CONTROL_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Register bank
    // ----------------------------------------------------------------
    // No reset here, so contents survive dynamic reset and plain power-down; the reset command reloads scaler select
    always_ff @(posedge SYS_CLK_IN) begin
        if (timeout) begin
            if (!sdio_lvl) begin
                bank_r[OFS_SCALER_SELECT] <= SCALER_SELECT_RST;
            end
        end else if (force16) begin
            bank_r[OFS_SCALER_SELECT][SC_PSC_MSB:SC_PSC_LSB] <= PSC_CODE_DIV16;
        end else if (wf_out_valid) begin
            if (wf_out_data[12:8] < 5'(NUM_REGS) &&
                wf_out_data[12:8] != OFS_TRANSMITTER_CONTROL) begin
                bank_r[wf_out_data[12:8]] <= wf_out_data[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Write buffer between the link and the bank
    // ----------------------------------------------------------------
    // A byte arriving while full is dropped; with a drain of one per
    // cycle against one byte per eight serial edges it cannot fill.
    bcg_fifo #(
        .WIDTH (WR_FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_in        (SYS_CLK_IN),
        .rst_in        (RST_IN),
        .in_valid_in   (wf_in_valid),
        .in_ready_out  (wf_in_ready),
        .in_data_in    (wf_in_data),
        .out_valid_out (wf_out_valid),
        .out_ready_in  (wf_out_ready),
        .out_data_out  (wf_out_data)
    );

    // ----------------------------------------------------------------
    // Outputs, all from flops
    // ----------------------------------------------------------------
    assign SDIO_OUT                = st_r.sdo;
    assign SDIO_OE_OUT             = st_r.sdo_oe;
    assign CLOCK_OUTPUT_PIN_OUT    = st_r.ck_out;
    assign CLOCK_OUTPUT_PIN_OE_OUT = st_r.ck_oe;
    assign TRANSMIT_DATA_OUT       = st_r.tx_data;
    assign OSC_RUN_OUT             = !st_r.transmitter_control[TXC_PD_BIT];

endmodule : bcg_top

// [tb/bcg_top_properties.sv]
// Checker for the baud clock generator's top-level pins.
// Assumes it is bound to bcg_top and sees only its ports.
`timescale 1ns/100ps
module bcg_top_properties #(
    parameter int PD_TIMEOUT = 65536
) (
    // Clock and reset
    input wire logic SYS_CLK_IN,
    input wire logic RST_IN,
    // Serial link
    input wire logic SCK_IN,
    input wire logic EN_IN,
    input wire logic SDIO_IN,
    input wire logic SDIO_OUT,
    input wire logic SDIO_OE_OUT,
    // Transmit side and clock pin
    input wire logic PA_ON_IN,
    input wire logic SYNC_EN_IN,
    input wire logic CLOCK_OUTPUT_PIN_OUT,
    input wire logic CLOCK_OUTPUT_PIN_OE_OUT,
    input wire logic TRANSMIT_DATA_OUT,
    input wire logic OSC_RUN_OUT
);
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (RST_IN);

    // ------------------------------------------------------------
    // Enable-low run length
    // ------------------------------------------------------------
    int lo_cnt_r;
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            lo_cnt_r <= 0;
        end else begin
            lo_cnt_r <= EN_IN ? 0 : lo_cnt_r + 1;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Read driver lets go a few clocks after the frame ends
    sdio_oe_end_a: assert property (!EN_IN [*5] |-> !SDIO_OE_OUT)
        else $error("read driver still on after frame end");
    // Read driver only starts inside a frame, after a full header
    sdio_oe_start_a: assert property ($rose(SDIO_OE_OUT) |-> EN_IN && $past(EN_IN, 8))
        else $error("read driver started outside a frame");
    // Read bit moves only after a serial clock edge
    rd_bit_hold_a: assert property ((SDIO_OE_OUT && $stable(SCK_IN)) [*5]
        |=> $stable(SDIO_OUT))
        else $error("read bit changed without a serial clock edge");
    // Long enable-low enters power-down in bounded time
    pd_timeout_a: assert property (lo_cnt_r == PD_TIMEOUT + 8 |-> !OSC_RUN_OUT)
        else $error("no power-down after long enable low");
    // Power-down is not entered early by the timer
    pd_early_a: assert property ($fell(OSC_RUN_OUT) && lo_cnt_r > 12
        |-> lo_cnt_r >= PD_TIMEOUT)
        else $error("power-down entered before the timeout");
    // Oscillator wakes only through a serial write
    osc_wake_a: assert property ($rose(OSC_RUN_OUT) |-> EN_IN || $past(EN_IN, 6))
        else $error("oscillator woke without a write");
    // Pin enable is steady while nothing can change it
    clock_output_pin_oe_hold_a: assert property ((!EN_IN && SDIO_IN && $stable(PA_ON_IN)) [*8]
        |=> $stable(CLOCK_OUTPUT_PIN_OE_OUT))
        else $error("clock pin enable changed with no cause");
    // Transparent data is retimed, never glitching on its own
    txd_retime_a: assert property ((!SYNC_EN_IN && PA_ON_IN
        && $stable({SDIO_IN, PA_ON_IN})) [*6] |=> $stable(TRANSMIT_DATA_OUT))
        else $error("transmit data moved with steady input");

    // Main scenarios seen
    cover property ($rose(SDIO_OE_OUT));
    cover property ($fell(OSC_RUN_OUT));
    cover property ($rose(CLOCK_OUTPUT_PIN_OE_OUT));
endmodule : bcg_top_properties

bind bcg_top bcg_top_properties #(.PD_TIMEOUT(PD_TIMEOUT)) bcg_top_properties_inst (
    .SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN), .SCK_IN(SCK_IN), .EN_IN(EN_IN),
    .SDIO_IN(SDIO_IN), .SDIO_OUT(SDIO_OUT), .SDIO_OE_OUT(SDIO_OE_OUT),
    .PA_ON_IN(PA_ON_IN), .SYNC_EN_IN(SYNC_EN_IN),
    .CLOCK_OUTPUT_PIN_OUT(CLOCK_OUTPUT_PIN_OUT),
    .CLOCK_OUTPUT_PIN_OE_OUT(CLOCK_OUTPUT_PIN_OE_OUT),
    .TRANSMIT_DATA_OUT(TRANSMIT_DATA_OUT), .OSC_RUN_OUT(OSC_RUN_OUT));

// [tb/bcg_host_model.sv]
// Host model driving the serial configuration link.
// Assumes the bench resolves the shared data line for it.
`timescale 1ns/100ps
module bcg_host_model (
    // Clock and resolved data line
    input  wire logic clk_in,
    input  wire logic sdio_line_in,
    // Link pins
    output logic      sck_out,
    output logic      en_out,
    output logic      sdio_drv_out
);
    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    initial begin
        sck_out      = 1'b0;
        en_out       = 1'b0;
        sdio_drv_out = 1'b1;
    end

    // Idle data level between frames
    task automatic set_sd(input logic v);
        @(posedge clk_in);
        sdio_drv_out <= v;
    endtask : set_sd

    // Header then nb bytes, first in wd[31:24]; reads return
    // right-aligned. Six-clock phases clear the pin synchronisers.
    task automatic xfer(input logic idle, input logic sd0, input logic [7:0] hdr,
                        input logic [31:0] wd, input int nb, output logic [31:0] rd);
        logic [39:0] sh;
        sh = {hdr, wd};
        rd = 32'h0;
        @(posedge clk_in);
        sck_out      <= idle;
        sdio_drv_out <= sd0;
        repeat (6) @(posedge clk_in);
        en_out <= 1'b1;
        repeat (6) @(posedge clk_in);
        for (int i = 0; i < 8 * (nb + 1); i++) begin
            sck_out <= ~idle;
            // Released line toggles, so a stale bit cannot pass
            sdio_drv_out <= (hdr[7] && i >= 8) ? ~sdio_drv_out : sh[39-i];
            repeat (6) @(posedge clk_in);
            if (i >= 8) begin
                rd = {rd[30:0], sdio_line_in};
            end
            sck_out <= idle;
            repeat (6) @(posedge clk_in);
        end
        en_out       <= 1'b0;
        sdio_drv_out <= 1'b1;
        repeat (6) @(posedge clk_in);
    endtask : xfer
endmodule : bcg_host_model

// [tb/testbench.sv]
// Self-checking bench for the baud clock generator.
// Assumes bcg_top, the host model and the bound checker are compiled.
`timescale 1ns/100ps
module testbench;
    import bcg_pkg::*;

    // ------------------------------------------------------------
    // Clock, reset and pins
    // ------------------------------------------------------------
    localparam int         PDT = 2000; // Short timeout keeps the run brief
    localparam logic [7:0] BDV [3] = '{8'h00, 8'h05, 8'hFF};
    localparam logic [2:0] PSV [3] = '{3'h0, 3'h1, 3'h0};
    logic        clk     = 1'b0;
    logic        rst     = 1'b1;
    logic        pa_on   = 1'b0;
    logic        sync_en = 1'b0;
    logic        sck, en, drv, sdio_out, sdio_oe, sdio_w;
    logic        ck_pin, ck_oe, txd, osc_run;
    logic [31:0] rd;
    int          n_errors    = 0;
    int          checks_done = 0;

    always #10 clk = ~clk;
    assign sdio_w = sdio_oe ? sdio_out : drv;

    bcg_top #(.PD_TIMEOUT(PDT)) bcg_top_inst (
        .SYS_CLK_IN(clk), .RST_IN(rst), .SCK_IN(sck), .EN_IN(en), .SDIO_IN(sdio_w),
        .SDIO_OUT(sdio_out), .SDIO_OE_OUT(sdio_oe), .PA_ON_IN(pa_on),
        .SYNC_EN_IN(sync_en), .CLOCK_OUTPUT_PIN_OUT(ck_pin),
        .CLOCK_OUTPUT_PIN_OE_OUT(ck_oe), .TRANSMIT_DATA_OUT(txd), .OSC_RUN_OUT(osc_run));
    bcg_host_model bcg_host_model_inst (
        .clk_in(clk), .sdio_line_in(sdio_w), .sck_out(sck), .en_out(en),
        .sdio_drv_out(drv));

    // ------------------------------------------------------------
    // Compare, access and closing tasks
    // ------------------------------------------------------------
    task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask : chk_byte

    task automatic chk_num(input string what, input int e, input int g);
        checks_done++;
        if (g != e) begin
            n_errors++;
            $display("FAIL %s expected %0d seen %0d", what, e, g);
        end
    endtask : chk_num

    task automatic wr(input logic [4:0] a, input logic [31:0] d, input int n);
        bcg_host_model_inst.xfer(1'b1, 1'b1, {3'h0, a}, d, n, rd);
    endtask : wr

    task automatic rd_chk(input logic idle, input logic [4:0] a, input logic [31:0] e,
                          input int n);
        bcg_host_model_inst.xfer(idle, 1'b1, {3'h4, a}, 32'h0, n, rd);
        for (int i = 0; i < n; i++) begin
            chk_byte("read byte", e[8*i +: 8], rd[8*i +: 8]);
        end
    endtask : rd_chk

    // Period and high time of the clock pin, in reference clocks
    task automatic period(input string what, input int e);
        time t0, t1;
        @(posedge ck_pin);
        t0 = $time;
        @(negedge ck_pin);
        t1 = $time;
        @(posedge ck_pin);
        chk_num(what, e, int'(($time - t0) / 20));
        chk_num("high time", e / 2, int'((t1 - t0) / 20));
    endtask : period

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    // Hang guard, well past the expected run length
    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        close_out();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        wr(5'h0D, 32'h5A00_3C8F, 4);
        rd_chk(1'b0, 5'h0D, 32'h5A00_3C8F, 4);
        wr(5'h00, 32'hA500_0000, 1);
        rd_chk(1'b1, 5'h00, 32'h0000_00A5, 1);
        wr(5'h13, 32'h77EE_0000, 2);
        rd_chk(1'b1, 5'h13, 32'h0000_7700, 2);
        bcg_host_model_inst.xfer(1'b1, 1'b0, 8'h90, 32'h0, 1, rd);
        chk_byte("forced scaler", 8'h93, rd[7:0]);
        $display("test bank finished");
        // Prescaler on the pin runs with the amplifier off
        for (int p = 1; p < 8; p++) begin
            wr(5'h10, {3'b101, 3'(p), 2'b00, 24'h0}, 1);
            period("prescaled period", 1 << p);
        end
        pa_on <= 1'b1;
        for (int j = 0; j < 3; j++) begin
            wr(5'h0F, {BDV[j], 3'b010, PSV[j], 2'b00, 16'h0}, 2);
            period("baud period", (1 << PSV[j]) * 2 * (BDV[j] + 1));
        end
        // Sync mode: data moves only on an afterscaler tick at a baud rise
        sync_en <= 1'b1;
        @(posedge ck_pin);
        bcg_host_model_inst.set_sd(1'b0);
        repeat (100) @(negedge clk);
        chk_byte("sync data held", 8'h01, {7'h0, txd});
        @(posedge ck_pin);
        @(negedge clk);
        chk_byte("sync data taken", 8'h00, {7'h0, txd});
        sync_en <= 1'b0;
        bcg_host_model_inst.set_sd(1'b0);
        repeat (8) @(negedge clk);
        chk_byte("data low", 8'h00, {7'h0, txd});
        bcg_host_model_inst.set_sd(1'b1);
        repeat (8) @(negedge clk);
        chk_byte("data high", 8'h01, {7'h0, txd});
        pa_on <= 1'b0;
        repeat (4) @(negedge clk);
        chk_byte("pin idle 010", 8'h00, {7'h0, ck_oe});
        wr(5'h10, 32'hC000_0000, 1);
        @(negedge clk);
        chk_byte("pin idle 110", 8'h02, {6'h0, ck_oe, ck_pin});
        wr(5'h10, 32'hE000_0000, 1);
        @(negedge clk);
        chk_byte("pin idle 111", 8'h03, {6'h0, ck_oe, ck_pin});
        wr(5'h0E, 32'h4000_0000, 1);
        @(negedge clk);
        chk_byte("pin power-down", 8'h00, {7'h0, ck_oe});
        $display("test clocks finished");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_chk(1'b1, 5'h0E, 32'h0000_00FF, 2);
        wr(5'h10, 32'hB000_0000, 1);
        repeat (PDT + 20) @(negedge clk);
        chk_byte("oscillator", 8'h00, {7'h0, osc_run});
        rd_chk(1'b1, 5'h0E, 32'h0000_0080, 1);
        wr(5'h0E, 32'h0000_0000, 1);
        wr(5'h10, 32'h6400_0000, 1);
        bcg_host_model_inst.set_sd(1'b0);
        repeat (PDT + 20) @(posedge clk);
        rd_chk(1'b1, 5'h0E, 32'h0080_FFB0, 3);
        $display("test power-down finished");
        close_out();
    end
endmodule : testbench
